// ==== rtl/gcp_pat_if.sv ====
// carrier between the bank and its pattern word store
`timescale 1ns/1ns
`default_nettype none
interface gcp_pat_if;
    logic we;
    logic [1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] raddr;
    logic [31:0] rdata;
    logic [127:0] bits;
    modport bank (output we, output waddr, output wdata, output wstrb, output raddr,
                  input rdata, input bits);
    modport store (input we, input waddr, input wdata, input wstrb, input raddr,
                   output rdata, output bits);
endinterface
`default_nettype wire

// ==== rtl/gcp_pat_store.sv ====
// four-word pattern store with registered read and a flat 128-bit view
`timescale 1ns/1ns
`default_nettype none
module gcp_pat_store (
    input wire logic ref_clk,
    input wire logic nrst,
    gcp_pat_if.store pif
);
    logic [31:0] word_q [gcp_pkg::NUM_WORDS];
    logic [31:0] rdata_q;

    // word n lands on pattern bits 32n+31 down to 32n
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < gcp_pkg::NUM_WORDS; i++) begin
            if (!nrst) begin
                word_q[i] <= gcp_pkg::WORD_RESET;
            end else if (pif.we && pif.waddr == i[1:0]) begin
                word_q[i] <= gcp_pkg::merge_bytes(word_q[i], pif.wdata, pif.wstrb);
            end
        end
    end

    // registered read keeps the bus answer off the array fan-in
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_q <= gcp_pkg::WORD_RESET;
        end else begin
            rdata_q <= word_q[pif.raddr];
        end
    end

    assign pif.rdata = rdata_q;
    assign pif.bits = {word_q[3], word_q[2], word_q[1], word_q[0]};
endmodule // gcp_pat_store
`default_nettype wire

// ==== rtl/gcp_pkg.sv ====
// constants and helpers shared by the colour and pattern register bank
// Functional notes
// - at 16 bpp each colour register is a full 16-bit RGB pixel colour.
// - the two source colours replace pixels when monochrome source data is expanded.
// - source bit zero selects the first source colour, bit one the second.
// - four pattern colours, numbered zero to three, colour expanded pattern data.
// - four 32-bit words form one 128-bit pattern, word zero lowest.
// - legacy emulation write and read ports serve emulation; read port resets to zero.
package gcp_pkg;
    localparam logic [15:0] OFF_SRC_COLOR_0 = 16'h810c;
    localparam logic [15:0] OFF_SRC_COLOR_1 = 16'h810e;
    localparam logic [15:0] OFF_PAT_COLOR_0 = 16'h8110;
    localparam logic [15:0] OFF_PAT_COLOR_1 = 16'h8112;
    localparam logic [15:0] OFF_PAT_COLOR_2 = 16'h8114;
    localparam logic [15:0] OFF_PAT_COLOR_3 = 16'h8116;
    localparam logic [15:0] OFF_PAT_WORD_0 = 16'h8120;
    localparam logic [15:0] OFF_PAT_WORD_1 = 16'h8124;
    localparam logic [15:0] OFF_PAT_WORD_2 = 16'h8128;
    localparam logic [15:0] OFF_PAT_WORD_3 = 16'h812c;
    localparam logic [15:0] OFF_LEGACY_WRITE = 16'h8140;
    localparam logic [15:0] OFF_LEGACY_READ = 16'h8144;
    localparam logic [15:0] COLOR_RESET = 16'h0000;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] LEGACY_READ_RESET = 32'h0000_0000;
    localparam logic [31:0] LEGACY_WRITE_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam int NUM_COLORS = 6;
    localparam int NUM_WORDS = 4;
    localparam int PAT_COLOR_BASE = 2;

    // byte-lane merge of a write into an existing 32-bit value
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage

// ==== rtl/gcp_regs.sv ====
// colour and pattern register bank with source and pattern colour expansion
`timescale 1ns/1ns
`default_nettype none
module gcp_regs (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] addr,
    input wire logic wr_en,
    input wire logic [3:0] wstrb,
    input wire logic [31:0] wdata,
    input wire logic rd_en,
    input wire logic expand_req,
    input wire logic mono_bit,
    input wire logic [1:0] pat_index,
    output logic [31:0] rdata_q,
    output logic rvalid_q,
    output logic [15:0] src_pixel_q,
    output logic [15:0] pat_pixel_q,
    output logic pixel_valid_q,
    output logic [127:0] pattern_bits_q,
    output logic [31:0] legacy_write_q,
    output logic legacy_write_pulse_q,
    output logic [31:0] legacy_read_q
);
    typedef enum logic [2:0] {
        GCP_SEL_NONE = 3'b001,
        GCP_SEL_REG = 3'b010,
        GCP_SEL_WORD = 3'b100
    } gcp_sel_type;

    gcp_pat_if pif ();

    logic [15:0] color_q [gcp_pkg::NUM_COLORS];
    logic [2:0] color_idx;
    logic color_hit;
    logic [1:0] word_idx;
    logic word_hit;
    logic legacy_w_hit;
    logic legacy_r_hit;
    logic [31:0] stage_q;
    gcp_sel_type sel_q;
    logic rd_pend_q;
    logic [31:0] stage_d;
    gcp_sel_type sel_d;
    logic [15:0] pat_sel_w;

    // address decode for the 16-bit colours, pattern words and legacy ports
    always_comb begin
        color_hit = 1'b1;
        color_idx = 3'd0;
        if (addr == gcp_pkg::OFF_SRC_COLOR_0) begin
            color_idx = 3'd0;
        end else if (addr == gcp_pkg::OFF_SRC_COLOR_1) begin
            color_idx = 3'd1;
        end else if (addr == gcp_pkg::OFF_PAT_COLOR_0) begin
            color_idx = 3'd2;
        end else if (addr == gcp_pkg::OFF_PAT_COLOR_1) begin
            color_idx = 3'd3;
        end else if (addr == gcp_pkg::OFF_PAT_COLOR_2) begin
            color_idx = 3'd4;
        end else if (addr == gcp_pkg::OFF_PAT_COLOR_3) begin
            color_idx = 3'd5;
        end else begin
            color_hit = 1'b0;
        end
    end

    always_comb begin
        word_hit = 1'b1;
        word_idx = 2'd0;
        if (addr == gcp_pkg::OFF_PAT_WORD_0) begin
            word_idx = 2'd0;
        end else if (addr == gcp_pkg::OFF_PAT_WORD_1) begin
            word_idx = 2'd1;
        end else if (addr == gcp_pkg::OFF_PAT_WORD_2) begin
            word_idx = 2'd2;
        end else if (addr == gcp_pkg::OFF_PAT_WORD_3) begin
            word_idx = 2'd3;
        end else begin
            word_hit = 1'b0;
        end
    end

    assign legacy_w_hit = (addr == gcp_pkg::OFF_LEGACY_WRITE);
    assign legacy_r_hit = (addr == gcp_pkg::OFF_LEGACY_READ);

    // colour registers: whole 16 bits stored, only lanes 0 and 1 matter
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < gcp_pkg::NUM_COLORS; i++) begin
            if (!nrst) begin
                color_q[i] <= gcp_pkg::COLOR_RESET;
            end else if (wr_en && color_hit && color_idx == i[2:0]) begin
                // size cast drops the upper lanes, which a colour register does not hold
                color_q[i] <= 16'(gcp_pkg::merge_bytes({16'h0000, color_q[i]}, wdata,
                                                       wstrb));
            end
        end
    end

    // pattern words live in the store; reads use the same decoded index
    assign pif.we = wr_en && word_hit;
    assign pif.waddr = word_idx;
    assign pif.wdata = wdata;
    assign pif.wstrb = wstrb;
    assign pif.raddr = word_idx;
    assign pattern_bits_q = pif.bits;

    gcp_pat_store u_store (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pif(pif)
    );

    // legacy emulation ports are plain storage handed to the emulation side
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            legacy_write_q <= gcp_pkg::LEGACY_WRITE_RESET;
            legacy_write_pulse_q <= 1'b0;
            legacy_read_q <= gcp_pkg::LEGACY_READ_RESET;
        end else begin
            legacy_write_pulse_q <= wr_en && legacy_w_hit;
            if (wr_en && legacy_w_hit) begin
                legacy_write_q <= gcp_pkg::merge_bytes(legacy_write_q, wdata, wstrb);
            end
            if (wr_en && legacy_r_hit) begin
                legacy_read_q <= gcp_pkg::merge_bytes(legacy_read_q, wdata, wstrb);
            end
        end
    end

    // read stage one: capture the non-array value and the source to pick
    always_comb begin
        stage_d = gcp_pkg::UNMAPPED_READ;
        sel_d = GCP_SEL_NONE;
        if (color_hit) begin
            stage_d = {16'h0000, color_q[color_idx]};
            sel_d = GCP_SEL_REG;
        end else if (word_hit) begin
            sel_d = GCP_SEL_WORD;
        end else if (legacy_w_hit) begin
            stage_d = legacy_write_q;
            sel_d = GCP_SEL_REG;
        end else if (legacy_r_hit) begin
            stage_d = legacy_read_q;
            sel_d = GCP_SEL_REG;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stage_q <= gcp_pkg::UNMAPPED_READ;
            sel_q <= GCP_SEL_NONE;
            rd_pend_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            sel_q <= sel_d;
            rd_pend_q <= rd_en;
        end
    end

    // read stage two: two-cycle answer so word reads align with colour reads
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_q <= gcp_pkg::UNMAPPED_READ;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_pend_q;
            if (rd_pend_q) begin
                case (sel_q)
                    GCP_SEL_WORD: begin
                        rdata_q <= pif.rdata;
                    end
                    GCP_SEL_REG: begin
                        rdata_q <= stage_q;
                    end
                    default: begin
                        rdata_q <= gcp_pkg::UNMAPPED_READ; // unmapped reads as zero
                    end
                endcase
            end
        end
    end

    // expansion: values pass whole; at 8 bpp software already doubled the index
    assign pat_sel_w = color_q[3'(gcp_pkg::PAT_COLOR_BASE) + {1'b0, pat_index}];

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            src_pixel_q <= gcp_pkg::COLOR_RESET;
            pat_pixel_q <= gcp_pkg::COLOR_RESET;
            pixel_valid_q <= 1'b0;
        end else begin
            pixel_valid_q <= expand_req;
            if (expand_req) begin
                src_pixel_q <= mono_bit ? color_q[1] : color_q[0];
                pat_pixel_q <= pat_sel_w;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_src_clear;
        expand_req && !mono_bit |=> src_pixel_q == $past(color_q[0]) && pixel_valid_q;
    endproperty
    a_src_clear: assert property (p_src_clear) else $error("clear bit wrong colour");

    property p_src_set;
        expand_req && mono_bit |=> src_pixel_q == $past(color_q[1]);
    endproperty
    a_src_set: assert property (p_src_set) else $error("set bit wrong colour");

    property p_full_rgb;
        wr_en && addr == gcp_pkg::OFF_SRC_COLOR_1 && wstrb == 4'hf ##1 expand_req && mono_bit
        |=> src_pixel_q == $past(wdata[15:0], 2);
    endproperty
    a_full_rgb: assert property (p_full_rgb) else $error("rgb colour not whole");

    property p_pat_color;
        expand_req |=> pat_pixel_q == $past(color_q[2 + pat_index]);
    endproperty
    a_pat_color: assert property (p_pat_color) else $error("pattern colour wrong");

    property p_word_three;
        wr_en && addr == gcp_pkg::OFF_PAT_WORD_3 && wstrb == 4'hf
        |=> pattern_bits_q[127:96] == $past(wdata);
    endproperty
    a_word_three: assert property (p_word_three) else $error("word three misplaced");

    property p_word_zero;
        wr_en && addr == gcp_pkg::OFF_PAT_WORD_0 && wstrb == 4'hf
        |=> pattern_bits_q[31:0] == $past(wdata);
    endproperty
    a_word_zero: assert property (p_word_zero) else $error("word zero misplaced");

    property p_legacy;
        wr_en && legacy_w_hit && wstrb == 4'hf
        |=> legacy_write_pulse_q && legacy_write_q == $past(wdata);
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy write lost");

    property p_after_reset;
        $rose(nrst) |-> legacy_read_q == 32'h0000_0000 && pattern_bits_q == 128'h0
                        && color_q[0] == 16'h0000;
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("not clear after reset");

    property p_readback;
        wr_en && addr == gcp_pkg::OFF_PAT_COLOR_2 && wstrb == 4'hf ##1
        rd_en && addr == gcp_pkg::OFF_PAT_COLOR_2 && !wr_en
        |-> ##2 rvalid_q && rdata_q == {16'h0000, $past(wdata[15:0], 3)};
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    c_mono: cover property (expand_req && mono_bit ##1 pixel_valid_q);
    c_word_read: cover property (rd_en && word_hit ##2 rvalid_q);
    c_legacy: cover property (legacy_write_pulse_q);
endmodule // gcp_regs
`default_nettype wire

// ==== tb/tb_gfx_color_pattern_regs.sv ====
// self-checking bench for the colour and pattern register bank
`timescale 1ns/1ns
`default_nettype none
module tb_gfx_color_pattern_regs;
    logic ref_clk, nrst, wr_en, rd_en, expand_req, mono_bit;
    logic [15:0] addr;
    logic [3:0] wstrb;
    logic [31:0] wdata;
    logic [1:0] pat_index;
    logic [31:0] rdata_q, legacy_write_q, legacy_read_q;
    logic rvalid_q, pixel_valid_q, legacy_write_pulse_q;
    logic [15:0] src_pixel_q, pat_pixel_q;
    logic [127:0] pattern_bits_q;
    int failures, tests_run, seed, pulses, exp_pulses;
    logic [31:0] mdl [logic [15:0]];
    logic [15:0] offs [12] = '{gcp_pkg::OFF_SRC_COLOR_0, gcp_pkg::OFF_SRC_COLOR_1,
        gcp_pkg::OFF_PAT_COLOR_0, gcp_pkg::OFF_PAT_COLOR_1, gcp_pkg::OFF_PAT_COLOR_2,
        gcp_pkg::OFF_PAT_COLOR_3, gcp_pkg::OFF_PAT_WORD_0, gcp_pkg::OFF_PAT_WORD_1,
        gcp_pkg::OFF_PAT_WORD_2, gcp_pkg::OFF_PAT_WORD_3, gcp_pkg::OFF_LEGACY_WRITE,
        gcp_pkg::OFF_LEGACY_READ};

    gcp_regs i_gcp_regs (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_en(wr_en),
        .wstrb(wstrb), .wdata(wdata), .rd_en(rd_en), .expand_req(expand_req),
        .mono_bit(mono_bit), .pat_index(pat_index), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
        .src_pixel_q(src_pixel_q), .pat_pixel_q(pat_pixel_q), .pixel_valid_q(pixel_valid_q),
        .pattern_bits_q(pattern_bits_q), .legacy_write_q(legacy_write_q),
        .legacy_write_pulse_q(legacy_write_pulse_q), .legacy_read_q(legacy_read_q));

    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // pulses are sampled once per edge, so a stretched pulse shows as a count mismatch
    always @(posedge ref_clk) begin
        if (nrst === 1'b1 && legacy_write_pulse_q === 1'b1) begin
            pulses++;
        end
    end

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // model write: only enabled lanes change, colour registers keep 16 bits
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wstrb <= s;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        if (mdl.exists(a)) begin
            for (int i = 0; i < 4; i++) begin
                if (s[i]) mdl[a][i*8 +: 8] = d[i*8 +: 8];
            end
            if (a < gcp_pkg::OFF_PAT_WORD_0) mdl[a][31:16] = 16'h0000;
            if (a == gcp_pkg::OFF_LEGACY_WRITE) exp_pulses++;
        end
    endtask

    task automatic rd(input logic [15:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        while (rvalid_q !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("rvalid", rvalid_q, 1'b1);
        check("read latency", n, 1);
        check("rdata", rdata_q, mdl.exists(a) ? mdl[a] : 32'h0000_0000);
    endtask

    // full colour write, then on the very next edge a read of it and an expansion
    task automatic wr_use(input logic [15:0] a, input logic [31:0] d, input logic m);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        expand_req <= 1'b1;
        mono_bit <= m;
        pat_index <= 2'd2;
        mdl[a] = {16'h0000, d[15:0]};
        @(posedge ref_clk);
        rd_en <= 1'b0;
        expand_req <= 1'b0;
        #1;
        check("pixel valid", pixel_valid_q, 1'b1);
        check("source pixel", src_pixel_q, mdl[offs[m]][15:0]);
        check("pattern pixel", pat_pixel_q, mdl[offs[4]][15:0]);
        @(posedge ref_clk);
        #1;
        check("rvalid", rvalid_q, 1'b1);
        check("rdata", rdata_q, mdl[a]);
    endtask

    task automatic rd_all();
        foreach (offs[i]) rd(offs[i]);
        check("pattern", pattern_bits_q, {mdl[offs[9]], mdl[offs[8]], mdl[offs[7]],
            mdl[offs[6]]});
        check("legacy write", legacy_write_q, mdl[offs[10]]);
        check("legacy read", legacy_read_q, mdl[offs[11]]);
    endtask

    task automatic expand(input logic m, input logic [1:0] idx);
        int n;
        n = 0;
        @(posedge ref_clk);
        expand_req <= 1'b1;
        mono_bit <= m;
        pat_index <= idx;
        @(posedge ref_clk);
        expand_req <= 1'b0;
        #1;
        while (pixel_valid_q !== 1'b1 && n < 3) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("pixel valid", pixel_valid_q, 1'b1);
        check("expand latency", n, 0);
        check("source pixel", src_pixel_q, mdl[offs[m]][15:0]);
        check("pattern pixel", pat_pixel_q, mdl[offs[2 + idx]][15:0]);
    endtask

    // watchdog, several times the expected run length
    initial begin
        #(40 * 6000);
        failures++;
        end_sim();
    end

    initial begin
        logic [31:0] r;
        int k;
        seed = 19815;
        {nrst, wr_en, rd_en, expand_req, mono_bit} = '0;
        addr = 16'h0000;
        wstrb = 4'h0;
        wdata = 32'h0000_0000;
        pat_index = 2'h0;
        foreach (offs[i]) mdl[offs[i]] = 32'h0000_0000;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        rd_all();
        // full writes; 8 bpp colour index duplicated, junk in the unused upper half
        repeat (2) begin
            foreach (offs[i]) begin
                r = $random(seed);
                wr(offs[i], (i < 6) ? {r[31:16], {2{r[7:0]}}} : r, 4'hf);
            end
            rd_all();
        end
        // partial lane writes, then unmapped and misaligned places
        repeat (24) begin
            k = $unsigned($random(seed)) % 12;
            r = $random(seed);
            wr(offs[k], $random(seed), r[3:0]);
        end
        wr(16'h8121, 32'hffff_ffff, 4'hf);
        wr(16'h8118, 32'hffff_ffff, 4'hf);
        rd(16'h8121);
        rd(16'h8200);
        rd_all();
        // every source bit against every pattern colour, fresh colours first
        foreach (offs[i]) if (i < 6) wr(offs[i], $random(seed), 4'h3);
        for (int m = 0; m < 2; m++) begin
            for (int p = 0; p < 4; p++) expand(m[0], p[1:0]);
        end
        // a colour written at one edge must be seen by a request on the next
        wr_use(gcp_pkg::OFF_SRC_COLOR_1, $random(seed), 1'b1);
        wr_use(gcp_pkg::OFF_PAT_COLOR_2, $random(seed), 1'b0);
        check("legacy pulses", pulses, exp_pulses);
        // second reset in mid-run clears every register
        @(posedge ref_clk);
        nrst <= 1'b0;
        @(posedge ref_clk);
        nrst <= 1'b1;
        foreach (offs[i]) mdl[offs[i]] = 32'h0000_0000;
        rd_all();
        end_sim();
    end
endmodule // tb_gfx_color_pattern_regs
`default_nettype wire
